// ### logic/atss_conv_timer.sv
// Conversion duration counter.
`timescale 1ns/1ps
module atss_conv_timer (
   // Clock and reset.
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control.
   input  wire logic       launch,
   input  wire logic       first_conv,
   input  wire logic [1:0] clk_sel,
   input  wire logic       abort,
   // Status.
   output logic            busy,
   output logic            done
);
   import atss_pkg::*;

   typedef struct packed {
      logic       busy;
      logic [9:0] cnt;
   } atss_tmr_s;

   atss_tmr_s r;
   atss_tmr_s next_r;

   always_comb begin
      next_r = r;
      if (launch) begin
         next_r.busy = 1'b1;
         next_r.cnt  = atss_conv_len(first_conv, clk_sel) - 10'h001;
      end else if (abort || (r.busy && r.cnt == 10'h000)) begin
         next_r.busy = 1'b0;
      end else if (r.busy) begin
         next_r.cnt = r.cnt - 10'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{busy: 1'b0, cnt: 10'h000};
      end else begin
         r <= next_r;
      end
   end

   assign busy = r.busy;
   assign done = r.busy && (r.cnt == 10'h000);

   ////////////////////////////////////////////////////////////////////////////////
   logic [9:0] elapsed;
   logic [9:0] len_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         elapsed <= 10'h000;
         len_q   <= 10'h000;
      end else if (launch) begin
         elapsed <= 10'h001;
         len_q   <= atss_conv_len(first_conv, clk_sel);
      end else begin
         elapsed <= elapsed + 10'h001;
      end
   end

   property p_len;
      @(posedge pclk) disable iff (!presetn) done |-> elapsed == len_q;
   endproperty
   a_len: assert property (p_len) else $error("conversion length wrong");

   property p_fast_first;
      @(posedge pclk) disable iff (!presetn)
         launch && first_conv && clk_sel == 2'h3 |=> r.cnt == 10'h043;
   endproperty
   a_fast_first: assert property (p_fast_first) else $error("first length not 68");

   property p_slow_scan;
      @(posedge pclk) disable iff (!presetn)
         launch && !first_conv && clk_sel == 2'h0 |=> r.cnt == 10'h1ff;
   endproperty
   a_slow_scan: assert property (p_slow_scan) else $error("scan length not 512");

endmodule : atss_conv_timer

// ### logic/atss_pkg.sv
// Constants, types and helpers shared by the converter sequencer files.
package atss_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets and decode.
   localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
   localparam logic [7:0] OFS_CONTROL     = 8'h04;
   localparam logic [7:0] OFS_STOP        = 8'h08;
   localparam logic [7:0] OFS_DATA_BASE   = 8'h40;
   localparam logic [7:0] DATA_MASK       = 8'hc3;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int CS_FLAG_BIT  = 7;
   localparam int CS_IE_BIT    = 6;
   localparam int CS_START_BIT = 5;
   localparam int CS_SCAN_BIT  = 4;
   localparam int CS_CH_LSB    = 0;
   localparam int CTL_TRG_LSB  = 6;
   localparam int CTL_CKS_LSB  = 2;
   localparam int STOP_BIT     = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Values after reset and fixed codes.
   localparam logic [1:0] RST_TRG      = 2'h0;
   localparam logic [1:0] RST_CKS      = 2'h0;
   localparam logic [3:0] RST_CH       = 4'h0;
   localparam logic       RST_STOP     = 1'b1;
   localparam logic [1:0] TRG_EXTERNAL = 2'h3;
   localparam logic [1:0] CTL_RSVD     = 2'h3;
   localparam logic [1:0] LAST_IN_GRP  = 2'h3;
   localparam logic [9:0] CODE_MIN     = 10'h000;
   localparam logic [9:0] CODE_MAX     = 10'h3ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Conversion lengths in states; one state is one pclk cycle.
   localparam logic [9:0] LEN_FIRST_00 = 10'h212;
   localparam logic [9:0] LEN_FIRST_01 = 10'h10a;
   localparam logic [9:0] LEN_FIRST_10 = 10'h086;
   localparam logic [9:0] LEN_FIRST_11 = 10'h044;
   localparam logic [9:0] LEN_SCAN_00  = 10'h200;
   localparam logic [9:0] LEN_SCAN_01  = 10'h100;
   localparam logic [9:0] LEN_SCAN_10  = 10'h080;
   localparam logic [9:0] LEN_SCAN_11  = 10'h040;

   typedef enum logic {ST_IDLE, ST_CONV} atss_state_e;

   // Conversion length for a first or a later conversion.
   function automatic logic [9:0] atss_conv_len(input logic first, input logic [1:0] cks);
      logic [9:0] len;
      len = LEN_SCAN_00;
      unique case (cks)
         2'h0: len = first ? LEN_FIRST_00 : LEN_SCAN_00;
         2'h1: len = first ? LEN_FIRST_01 : LEN_SCAN_01;
         2'h2: len = first ? LEN_FIRST_10 : LEN_SCAN_10;
         2'h3: len = first ? LEN_FIRST_11 : LEN_SCAN_11;
      endcase
      return len;
   endfunction : atss_conv_len

   // True for an address inside the result window.
   function automatic logic atss_is_data(input logic [7:0] a);
      return (a & DATA_MASK) == OFS_DATA_BASE;
   endfunction : atss_is_data

endpackage : atss_pkg

// ### logic/atss_top.sv
// APB register file and single or scan conversion sequencer.
`timescale 1ns/1ps
module atss_top (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Converter core and pins.
   input  wire logic        ext_convert_trigger_pin,
   input  wire logic [9:0]  conv_code,
   output logic [3:0]       analog_channel,
   output logic             conv_active,
   output logic             conversion_end_irq
);
   import atss_pkg::*;

   typedef struct packed {
      atss_state_e     st;
      logic            conversion_end_flag;
      logic            end_irq_enable;
      logic            convert_start_bit;
      logic            scan;
      logic [3:0]      ch_sel;
      logic [1:0]      trigger_source;
      logic [1:0]      conv_clock_select;
      logic            stop;
      logic [3:0]      cur_ch;
      logic [31:0]     rdata;
      logic [15:0][9:0] data;
   } atss_main_s;

   atss_main_s r;
   atss_main_s next_r;

   logic trig_fall;
   logic launch;
   logic first_conv;
   logic abort;
   logic tmr_busy;
   logic done;
   logic acc;
   logic wr;
   logic cs_wr;
   logic flag_set;
   logic flag_clr;
   logic mapped;

   ////////////////////////////////////////////////////////////////////////////////
   // Submodules.
   atss_trig_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (ext_convert_trigger_pin),
      .fall    (trig_fall)
   );

   atss_conv_timer u_timer (
      .pclk       (pclk),
      .presetn    (presetn),
      .launch     (launch),
      .first_conv (first_conv),
      .clk_sel    (r.conv_clock_select),
      .abort      (abort),
      .busy       (tmr_busy),
      .done       (done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   assign acc    = psel && penable;
   assign wr     = acc && pwrite;
   assign mapped = atss_is_data(paddr) || paddr == OFS_CTRL_STATUS ||
                   paddr == OFS_CONTROL || paddr == OFS_STOP;
   assign cs_wr  = wr && !r.stop && paddr == OFS_CTRL_STATUS;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state.
   always_comb begin
      next_r     = r;
      launch     = 1'b0;
      first_conv = 1'b1;
      abort      = 1'b0;
      flag_set   = 1'b0;
      flag_clr   = cs_wr && !pwdata[CS_FLAG_BIT];

      // Read data is captured in the setup phase.
      if (psel && !penable) begin
         next_r.rdata = 32'h0000_0000;
         if (paddr == OFS_STOP) begin
            next_r.rdata[STOP_BIT] = r.stop;
         end else if (!r.stop) begin
            if (paddr == OFS_CTRL_STATUS) begin
               next_r.rdata[7:0] = {r.conversion_end_flag, r.end_irq_enable,
                                    r.convert_start_bit, r.scan, r.ch_sel};
            end else if (paddr == OFS_CONTROL) begin
               next_r.rdata[7:0] = {r.trigger_source, CTL_RSVD,
                                    r.conv_clock_select, CTL_RSVD};
            end else if (atss_is_data(paddr)) begin
               next_r.rdata[9:0] = r.data[paddr[5:2]];
            end
         end
      end

      // Register writes.
      if (wr && paddr == OFS_STOP) begin
         next_r.stop = pwdata[STOP_BIT];
      end
      if (cs_wr) begin
         next_r.end_irq_enable    = pwdata[CS_IE_BIT];
         next_r.convert_start_bit = pwdata[CS_START_BIT];
         next_r.scan              = pwdata[CS_SCAN_BIT];
         next_r.ch_sel            = pwdata[CS_CH_LSB +: 4];
      end
      if (wr && !r.stop && paddr == OFS_CONTROL) begin
         next_r.trigger_source    = pwdata[CTL_TRG_LSB +: 2];
         next_r.conv_clock_select = pwdata[CTL_CKS_LSB +: 2];
      end

      // Sequencer.
      unique case (r.st)
         ST_IDLE: begin
            if (r.convert_start_bit && !r.stop) begin
               launch = 1'b1;
               next_r.st = ST_CONV;
               if (r.scan) begin
                  next_r.cur_ch = {r.ch_sel[3:2], 2'h0};
               end else begin
                  next_r.cur_ch = r.ch_sel;
               end
            end
         end
         ST_CONV: begin
            if (!r.convert_start_bit || r.stop) begin
               abort     = 1'b1;
               next_r.st = ST_IDLE;
            end else if (done) begin
               next_r.data[r.cur_ch] = conv_code;
               if (!r.scan) begin
                  flag_set  = 1'b1;
                  next_r.st = ST_IDLE;
                  if (!cs_wr) begin
                     next_r.convert_start_bit = 1'b0;
                  end
               end else begin
                  flag_set      = r.cur_ch[1:0] == LAST_IN_GRP;
                  next_r.cur_ch = {r.cur_ch[3:2], r.cur_ch[1:0] + 2'h1};
                  launch        = 1'b1;
                  first_conv    = 1'b0;
               end
            end
         end
      endcase

      // The flag clears on a written zero; a set in the same cycle wins.
      next_r.conversion_end_flag = (r.conversion_end_flag && !flag_clr) || flag_set;

      // The external edge sets the start bit only when that source is chosen.
      if (!r.stop && r.trigger_source == TRG_EXTERNAL && trig_fall) begin
         next_r.convert_start_bit = 1'b1;
      end

      // Module stop halts everything.
      if (r.stop) begin
         next_r.convert_start_bit = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{st: ST_IDLE, conversion_end_flag: 1'b0, end_irq_enable: 1'b0,
                convert_start_bit: 1'b0, scan: 1'b0, ch_sel: RST_CH,
                trigger_source: RST_TRG, conv_clock_select: RST_CKS,
                stop: RST_STOP, cur_ch: RST_CH, rdata: 32'h0000_0000,
                data: '0};
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign prdata             = r.rdata;
   assign pready             = 1'b1;
   assign pslverr            = acc && !mapped;
   assign analog_channel     = r.cur_ch;
   assign conv_active        = tmr_busy;
   assign conversion_end_irq = r.conversion_end_flag && r.end_irq_enable;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_trig_start;
      !r.stop && r.trigger_source == TRG_EXTERNAL && trig_fall |=> r.convert_start_bit;
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("edge did not start");

   property p_trig_ignored;
      r.trigger_source != TRG_EXTERNAL && !cs_wr && r.st == ST_IDLE &&
         !r.convert_start_bit |=> !r.convert_start_bit;
   endproperty
   a_trig_ignored: assert property (p_trig_ignored) else $error("pin acted");

   property p_single_end;
      r.st == ST_CONV && done && !r.scan && r.convert_start_bit && !r.stop && !cs_wr &&
         !(r.trigger_source == TRG_EXTERNAL && trig_fall)
         |=> !r.convert_start_bit && r.conversion_end_flag && r.st == ST_IDLE;
   endproperty
   a_single_end: assert property (p_single_end) else $error("single end wrong");

   property p_irq;
      r.st == ST_CONV && done && !r.scan && r.end_irq_enable && r.convert_start_bit &&
         !r.stop && !cs_wr |=> conversion_end_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("no end interrupt");

   property p_stop_hold;
      r.stop |=> r.st == ST_IDLE && !r.convert_start_bit && !tmr_busy;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("ran while stopped");

   property p_stop_write;
      r.stop && wr && paddr == OFS_CONTROL |=> $stable(r.trigger_source) &&
         $stable(r.conv_clock_select);
   endproperty
   a_stop_write: assert property (p_stop_write) else $error("write while stopped");

   property p_result;
      r.st == ST_CONV && done && r.convert_start_bit && !r.stop
         |=> r.data[$past(r.cur_ch)] == $past(conv_code);
   endproperty
   a_result: assert property (p_result) else $error("result not stored");

   property p_scan_wrap;
      r.st == ST_CONV && done && r.scan && r.cur_ch[1:0] == LAST_IN_GRP &&
         r.convert_start_bit && !r.stop && !wr |=> r.cur_ch[1:0] == 2'h0 &&
         r.conversion_end_flag && r.st == ST_CONV ##1 tmr_busy;
   endproperty
   a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap");

   property p_scan_first;
      r.st == ST_IDLE && r.convert_start_bit && !r.stop && r.scan && !cs_wr
         |=> r.cur_ch == {r.ch_sel[3:2], 2'h0};
   endproperty
   a_scan_first: assert property (p_scan_first) else $error("bad first channel");

   property p_start_hold;
      r.st == ST_CONV && !done && r.convert_start_bit && !r.stop && !cs_wr
         |=> r.convert_start_bit;
   endproperty
   a_start_hold: assert property (p_start_hold) else $error("start dropped early");

   property p_wait_idle;
      r.st == ST_IDLE && !r.convert_start_bit |=> !tmr_busy;
   endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("ran without start");

   property p_stop_read;
      r.stop && psel && !penable && paddr == OFS_CTRL_STATUS
         |=> prdata == 32'h0000_0000;
   endproperty
   a_stop_read: assert property (p_stop_read) else $error("read while stopped");

   property p_data_range;
      psel && !penable && atss_is_data(paddr)
         |=> prdata[31:10] == 22'h00_0000;
   endproperty
   a_data_range: assert property (p_data_range) else $error("result upper bits set");

   property p_flag_wins;
      flag_set |=> r.conversion_end_flag;
   endproperty
   a_flag_wins: assert property (p_flag_wins) else $error("flag set lost");

   property p_scan_step;
      r.st == ST_CONV && done && r.scan && r.convert_start_bit && !r.stop
         |=> r.cur_ch[3:2] == $past(r.cur_ch[3:2]) &&
         r.cur_ch[1:0] == 2'($past(r.cur_ch[1:0]) + 2'h1);
   endproperty
   a_scan_step: assert property (p_scan_step) else $error("scan step wrong");

   property p_stop_launch;
      r.stop |-> !launch;
   endproperty
   a_stop_launch: assert property (p_stop_launch) else $error("stopped launch");

   c_single: cover property (r.st == ST_CONV && done && !r.scan);
   c_scan_wrap: cover property (r.st == ST_CONV && done && r.scan && r.cur_ch[1:0] == 2'h3);
   c_trigger: cover property (r.trigger_source == TRG_EXTERNAL && trig_fall && !r.stop);
   c_release: cover property (r.stop ##1 !r.stop);
   c_abort: cover property (abort);

endmodule : atss_top

// ### logic/atss_trig_sync.sv
// Trigger pin synchroniser with falling-edge detector.
`timescale 1ns/1ps
module atss_trig_sync (
   // Clock and reset.
   input  wire logic pclk,
   input  wire logic presetn,
   // Pin and event.
   input  wire logic pin,
   output logic      fall
);
   import atss_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } atss_sync_s;

   atss_sync_s r;
   atss_sync_s next_r;

   ////////////////////////////////////////////////////////////////////////////////
   // A change counts once the second and third stages agree.
   always_comb begin
      next_r    = r;
      next_r.s1 = pin;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      if (r.s2 == r.s3) begin
         next_r.lvl = r.s3;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
      end else begin
         r <= next_r;
      end
   end

   assign fall = r.lvl && (r.s2 == r.s3) && !r.s3;

   ////////////////////////////////////////////////////////////////////////////////
   property p_one_fall;
      @(posedge pclk) disable iff (!presetn) fall |=> !fall;
   endproperty
   a_one_fall: assert property (p_one_fall) else $error("trigger edge gave two starts");

endmodule : atss_trig_sync

// ### sim/adc_trigger_scan_sequencer_tb.sv
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
module adc_trigger_scan_sequencer_tb;
   import atss_pkg::*;
   localparam int LIMIT = 20000;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        trig_pin, conv_active, irq, load;
   logic [9:0]  conv_code, load_val;
   logic [3:0]  analog_channel, load_ch;
   int          bad_count, checks, cyc, seed;
   int          exp_code [16];
   int          len_first [4] = '{530, 266, 134, 68};
   int          len_scan [4] = '{512, 256, 128, 64};

   atss_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_convert_trigger_pin(trig_pin), .conv_code(conv_code),
      .analog_channel(analog_channel), .conv_active(conv_active), .conversion_end_irq(irq));
   atss_core_model core (.pclk(pclk), .presetn(presetn), .analog_channel(analog_channel),
      .conv_active(conv_active), .load(load), .load_ch(load_ch), .load_val(load_val),
      .conv_code(conv_code));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare, report and bus tasks.
   task automatic chk_w(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_w

   task automatic chk_n(input string what, input int exp, input int got);
      checks++;
      if (got != exp) begin
         bad_count++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_n

   task automatic end_sim();
      $display("Checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_act(input logic v);
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (conv_active !== v && k < 3000);
   endtask : wait_act

   task automatic wait_ch(input logic [3:0] c);
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (analog_channel !== c && k < 3000);
   endtask : wait_ch

   task automatic pulse();
      @(posedge pclk);
      trig_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      trig_pin <= 1'b1;
      repeat (20) @(posedge pclk);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic single(input int cks, input logic [3:0] ch);
      int t;
      apb(1'b1, OFS_CONTROL, 32'(cks << CTL_CKS_LSB));
      apb(1'b0, OFS_CONTROL, 0);
      chk_w("control", 32'h0000_0033 | 32'(cks << CTL_CKS_LSB), rd);
      apb(1'b1, OFS_CTRL_STATUS, 32'h0000_0060 | 32'(ch));
      wait_act(1'b1);
      t = cyc;
      wait_act(1'b0);
      chk_n("single length", len_first[cks], cyc - t);
      apb(1'b0, OFS_CTRL_STATUS, 0);
      chk_w("status", 32'h0000_00c0 | 32'(ch), rd);
      chk_w("irq", 1'b1, irq);
      apb(1'b0, OFS_DATA_BASE | {2'b00, ch, 2'b00}, 0);
      chk_w("result", exp_code[ch], rd);
      apb(1'b1, OFS_CTRL_STATUS, 0);
   endtask : single

   task automatic scan(input int cks);
      int t [4];
      logic [3:0] base;
      base = 4'(cks * 4);
      apb(1'b1, OFS_CONTROL, 32'(cks << CTL_CKS_LSB));
      apb(1'b1, OFS_CTRL_STATUS, 32'h0000_0070 | 32'(cks << 2));
      for (int k = 1; k < 4; k++) begin
         wait_ch(base + 4'(k));
         t[k] = cyc;
      end
      wait_ch(base);
      t[0] = cyc;
      chk_n("scan length", len_scan[cks], t[2] - t[1]);
      chk_n("scan length", len_scan[cks], t[3] - t[2]);
      chk_n("scan wrap", len_scan[cks], t[0] - t[3]);
      repeat (2) @(posedge pclk);
      chk_w("scan irq", 1'b1, irq);
      apb(1'b1, OFS_CTRL_STATUS, 32'h0000_0080);
      @(negedge pclk);
      chk_w("masked irq", 1'b0, irq);
      apb(1'b0, OFS_CTRL_STATUS, 0);
      chk_w("flag held", 32'h0000_0080, rd);
      for (int k = 0; k < 4; k++) begin
         apb(1'b0, OFS_DATA_BASE | {2'b00, base + 4'(k), 2'b00}, 0);
         chk_w("scan result", exp_code[base + 4'(k)], rd);
      end
      apb(1'b1, OFS_CTRL_STATUS, 0);
   endtask : scan

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         bad_count++;
         end_sim();
      end
   end

   initial begin
      seed = 32'hc1d4_0fa2;
      {presetn, psel, penable, pwrite, paddr, pwdata, load, load_ch, load_val} = '0;
      trig_pin = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         exp_code[c] = (c == 0) ? 0 : (c == 15) ? 32'h3ff : ($random(seed) & 32'h3ff);
         @(posedge pclk);
         load     <= 1'b1;
         load_ch  <= 4'(c);
         load_val <= 10'(exp_code[c]);
      end
      @(posedge pclk);
      load <= 1'b0;
      apb(1'b0, OFS_STOP, 0);
      chk_w("stop reset", 1, rd);
      apb(1'b1, OFS_CTRL_STATUS, 32'h0000_0065);
      apb(1'b1, OFS_CONTROL, 32'h0000_00cc);
      repeat (4) @(posedge pclk);
      chk_w("stopped active", 1'b0, conv_active);
      apb(1'b0, 8'h0c, 0);
      chk_w("unmapped error", 1'b1, err);
      apb(1'b1, OFS_STOP, 0);
      apb(1'b0, OFS_CTRL_STATUS, 0);
      chk_w("write while stopped", 0, rd);
      apb(1'b0, OFS_CONTROL, 0);
      chk_w("control while stopped", 32'h0000_0033, rd);
      single(0, 4'h3);
      single(1, 4'hf);
      single(2, 4'h0);
      single(3, 4'h7);
      for (int k = 0; k < 4; k++) begin
         scan(k);
      end
      apb(1'b1, OFS_CONTROL, 32'h0000_000c);
      apb(1'b1, OFS_CTRL_STATUS, 32'h0000_0006);
      pulse();
      chk_w("trigger ignored", 1'b0, conv_active);
      apb(1'b1, OFS_CONTROL, 32'h0000_00cc);
      pulse();
      chk_w("trigger start", 1'b1, conv_active);
      wait_act(1'b0);
      apb(1'b0, OFS_CTRL_STATUS, 0);
      chk_w("trigger status", 32'h0000_0086, rd);
      apb(1'b0, OFS_DATA_BASE | 8'h18, 0);
      chk_w("trigger result", exp_code[6], rd);
      repeat (100) @(posedge pclk);
      chk_w("one start", 1'b0, conv_active);
      apb(1'b1, OFS_CTRL_STATUS, 32'h0000_0070);
      wait_act(1'b1);
      apb(1'b1, OFS_STOP, 1);
      repeat (3) @(posedge pclk);
      chk_w("stop aborts", 1'b0, conv_active);
      apb(1'b0, OFS_CTRL_STATUS, 0);
      chk_w("stopped read", 0, rd);
      end_sim();
   end
endmodule : adc_trigger_scan_sequencer_tb

// ### sim/atss_core_model.sv
// Converter core model that answers each channel with a loaded code.
`timescale 1ns/1ps
module atss_core_model (
   // Clock and reset.
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Sequencer side.
   input  wire logic [3:0] analog_channel,
   input  wire logic       conv_active,
   // Code table load.
   input  wire logic       load,
   input  wire logic [3:0] load_ch,
   input  wire logic [9:0] load_val,
   output logic [9:0]      conv_code
);
   logic [9:0] code_q [16];
   logic [9:0] noise;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         noise <= 10'h155;
      end else begin
         noise <= ~noise;
         if (load) begin
            code_q[load_ch] <= load_val;
         end
      end
   end

   // Codes are unsigned 10-bit; outside a conversion the bus toggles.
   assign conv_code = conv_active ? code_q[analog_channel] : noise;
endmodule : atss_core_model
